// ### design/fmc_cmd_decoder.sv
`timescale 1ns/10ps
// Behaviour
// - Register dump returns parameters, no drive activity
// - Read ID reports first error-free ID field
// - Perpendicular mode takes one parameter byte
// - Invalid opcode: standby, result byte 80h
// - Lock result echoes lock bit at bit4
// - Dump shared byte holds sectors after format
// - Dump shared byte holds end-of-track after read/write
// - Command drive bits stay internal only
module fmc_cmd_decoder
	import fmc_pkg::*;
(
	input  wire logic       i_sys_clk,      // System clock
	input  wire logic       i_rst_n,        // Sync reset, active low
	input  wire logic       i_cmd_valid,    // Command byte offered
	input  wire logic [7:0] i_cmd_data,     // Command byte
	output logic            o_cmd_ready,    // Byte accepted
	input  wire logic       i_ext_claim,    // Opcode owned elsewhere
	output logic            o_res_valid,    // Result byte offered
	output logic [7:0]      o_res_data,     // Result byte
	input  wire logic       i_res_ready,    // Host takes result byte
	input  wire logic [3:0] i_step_rate_time,  // Specify setting
	input  wire logic [3:0] i_head_unload_time, // Specify setting
	input  wire logic [6:0] i_head_load_time,   // Specify setting
	input  wire logic       i_non_dma_select,   // Specify setting
	input  wire logic [7:0] i_sectors_per_cylinder, // Last format
	input  wire logic [7:0] i_end_of_track_sector,  // Last read/write
	input  wire logic       i_last_was_format,  // Format came last
	input  wire logic       i_implied_seek_enable, // Configure bit
	input  wire logic       i_fifo_disable_bit, // Configure bit
	input  wire logic       i_poll_disable,     // Configure bit
	input  wire logic [3:0] i_fifo_threshold,   // Configure field
	input  wire logic [7:0] i_precomp_start_track, // Configure field
	input  wire logic       i_pcn_load,     // Other seek updates cyl
	input  wire logic [1:0] i_pcn_drive,    // Drive of that update
	input  wire logic [7:0] i_pcn_value,    // New cylinder value
	output logic            o_step,         // Head step pulse
	output logic            o_step_dir,     // Step direction, 1 inward
	output logic            o_seek_done,    // Relative seek finished
	output logic            o_rdid_req,     // Ask ID reader to search
	output logic            o_rdid_head,    // Head for ID search
	output logic            o_rdid_dens,    // Density for ID search
	input  wire logic       i_id_valid,     // ID field found
	input  wire logic       i_id_crc_err,   // That field had an error
	input  wire logic       i_id_abort,     // Search gave up
	input  wire logic [7:0] i_id_st0,       // Status bytes of search
	input  wire logic [7:0] i_id_st1,       // Status byte 1
	input  wire logic [7:0] i_id_st2,       // Status byte 2
	input  wire logic [31:0] i_id_chrn,     // C,H,R,N high to low
	output logic            o_standby,      // Idle after invalid code
	output logic            o_lock,         // Lock setting
	output logic [7:0]      o_perp_mode     // Perpendicular setting
);
	fmc_state_e state_reg;
	fmc_kind_e  kind_reg;
	fmc_kind_e  kind_next;
	logic [1:0] npar_reg;
	logic [7:0] par_reg [2];
	logic [7:0] pcn_reg [4];
	logic [7:0] res_mem [NRES_DUMP];
	logic [3:0] res_len_reg;
	logic [3:0] res_idx_reg;
	logic       seek_start;
	logic       seek_done;
	logic [1:0] sel_drv;
	logic       take_cmd;
	logic       take_res;

	assign o_cmd_ready = (state_reg == FMC_S_IDLE)
		|| (state_reg == FMC_S_PARAM);
	assign take_cmd = i_cmd_valid && o_cmd_ready;
	assign take_res = o_res_valid && i_res_ready;
	// Drive bits only index internal state, never a pin
	assign sel_drv  = par_reg[0][1:0];

	// Opcode decode; neighbours' opcodes are left alone
	always_comb begin
		kind_next = FMC_K_INVAL;
		if ((i_cmd_data & MSK_REL_SEEK) == OP_REL_SEEK)
			kind_next = FMC_K_SEEK;
		else if (i_cmd_data == OP_REG_DUMP)
			kind_next = FMC_K_DUMP;
		else if ((i_cmd_data & MSK_READ_ID) == OP_READ_ID)
			kind_next = FMC_K_RDID;
		else if (i_cmd_data == OP_PERP_MODE)
			kind_next = FMC_K_PERP;
		else if ((i_cmd_data & MSK_LOCK) == OP_LOCK)
			kind_next = FMC_K_LOCK;
		else if (i_ext_claim)
			kind_next = FMC_K_NONE;
	end

	// Phase sequencer
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state_reg <= FMC_S_IDLE;
			kind_reg  <= FMC_K_NONE;
			npar_reg  <= 2'd0;
		end else begin
			unique case (state_reg)
			FMC_S_IDLE: if (take_cmd) begin
				kind_reg <= kind_next;
				unique case (kind_next)
				FMC_K_SEEK: begin
					npar_reg  <= NPAR_REL_SEEK;
					state_reg <= FMC_S_PARAM;
				end
				FMC_K_RDID, FMC_K_PERP: begin
					npar_reg  <= NPAR_ONE;
					state_reg <= FMC_S_PARAM;
				end
				FMC_K_NONE: state_reg <= FMC_S_IDLE;
				default:    state_reg <= FMC_S_EXEC;
				endcase
			end
			FMC_S_PARAM: if (take_cmd) begin
				npar_reg <= npar_reg - 2'd1;
				if (npar_reg == 2'd1)
					state_reg <= FMC_S_EXEC;
			end
			FMC_S_EXEC: begin
				if (kind_reg == FMC_K_PERP)
					state_reg <= FMC_S_IDLE;
				else if (kind_reg == FMC_K_SEEK) begin
					if (seek_done)
						state_reg <= FMC_S_IDLE;
				end else if (kind_reg == FMC_K_RDID) begin
					if ((i_id_valid && !i_id_crc_err) || i_id_abort)
						state_reg <= FMC_S_RESULT;
				end else
					state_reg <= FMC_S_RESULT;
			end
			FMC_S_RESULT: if (take_res && res_idx_reg == res_len_reg - 4'd1)
				state_reg <= FMC_S_IDLE;
			endcase
		end
	end

	// Parameter bytes land in order
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			par_reg[0] <= 8'h00;
			par_reg[1] <= 8'h00;
		end else if (take_cmd && state_reg == FMC_S_PARAM) begin
			if (npar_reg == 2'd2 || kind_reg != FMC_K_SEEK)
				par_reg[0] <= i_cmd_data;
			else
				par_reg[1] <= i_cmd_data;
		end
	end

	// Opcode option bits kept for execution
	logic dir_reg;
	logic dens_reg;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			dir_reg  <= 1'b0;
			dens_reg <= 1'b0;
			o_lock   <= 1'b0;
		end else if (take_cmd && state_reg == FMC_S_IDLE) begin
			dir_reg  <= i_cmd_data[DIR_BIT];
			dens_reg <= i_cmd_data[DIR_BIT];
			if (kind_next == FMC_K_LOCK)
				o_lock <= i_cmd_data[LOCK_BIT];
		end
	end

	// Perpendicular setting; bit 6 forced zero
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			o_perp_mode <= PERP_RST;
		else if (state_reg == FMC_S_EXEC && kind_reg == FMC_K_PERP) begin
			o_perp_mode <= par_reg[0];
			o_perp_mode[PERP_ZERO_BIT] <= 1'b0;
		end
	end

	// Standby after an invalid code, left on the next byte
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n)
			o_standby <= 1'b0;
		else if (take_cmd)
			o_standby <= (state_reg == FMC_S_IDLE)
				&& (kind_next == FMC_K_INVAL);
	end

	// Step burst; drive pin selection stays with the host
	// Start drops once done shows, else a second burst would follow
	assign seek_start = (state_reg == FMC_S_EXEC)
		&& (kind_reg == FMC_K_SEEK) && !seek_done;
	assign o_step_dir = dir_reg;
	assign o_seek_done = seek_done;
	fmc_stepper u_step (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_start   (seek_start),
		.i_count   (par_reg[1]),
		.o_step    (o_step),
		.o_done    (seek_done)
	);

	// Present cylinders; relative seek wins over a same-cycle load
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			for (int d = 0; d < 4; d++)
				pcn_reg[d] <= PCN_RST;
		end else if (seek_done) begin
			if (dir_reg)
				pcn_reg[sel_drv] <= pcn_reg[sel_drv] + par_reg[1];
			else
				pcn_reg[sel_drv] <= pcn_reg[sel_drv] - par_reg[1];
		end else if (i_pcn_load)
			pcn_reg[i_pcn_drive] <= i_pcn_value;
	end

	// ID search request; the reader owns drive activity
	assign o_rdid_req  = (state_reg == FMC_S_EXEC) && (kind_reg == FMC_K_RDID);
	assign o_rdid_head = par_reg[0][2];
	assign o_rdid_dens = dens_reg;

	// Result snapshot taken as execution ends
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			res_len_reg <= NRES_ONE;
			for (int i = 0; i < NRES_DUMP; i++)
				res_mem[i] <= 8'h00;
		end else if (state_reg == FMC_S_EXEC) begin
			unique case (kind_reg)
			FMC_K_DUMP: begin
				res_len_reg <= NRES_DUMP;
				for (int d = 0; d < 4; d++)
					res_mem[d] <= pcn_reg[d];
				res_mem[4] <= {i_step_rate_time, i_head_unload_time};
				res_mem[5] <= {i_head_load_time, i_non_dma_select};
				res_mem[6] <= i_last_was_format ? i_sectors_per_cylinder
					: i_end_of_track_sector;
				res_mem[7] <= {o_lock, 1'b0, o_perp_mode[5:0]};
				res_mem[8] <= {1'b0, i_implied_seek_enable,
					i_fifo_disable_bit, i_poll_disable, i_fifo_threshold};
				res_mem[9] <= i_precomp_start_track;
			end
			FMC_K_RDID: begin
				res_len_reg <= NRES_READ_ID;
				res_mem[0]  <= i_id_st0;
				res_mem[1]  <= i_id_st1;
				res_mem[2]  <= i_id_st2;
				for (int b = 0; b < 4; b++)
					res_mem[3 + b] <= i_id_chrn[31 - 8 * b -: 8];
			end
			FMC_K_LOCK: begin
				res_len_reg <= NRES_ONE;
				res_mem[0]  <= 8'h00;
				res_mem[0][LOCK_RES_BIT] <= o_lock;
			end
			FMC_K_INVAL: begin
				res_len_reg <= NRES_ONE;
				res_mem[0]  <= ST0_INVALID;
			end
			default: res_len_reg <= res_len_reg;
			endcase
		end
	end

	// Result bytes, one bubble cycle between bytes
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			o_res_valid <= 1'b0;
			o_res_data  <= 8'h00;
			res_idx_reg <= 4'd0;
		end else if (state_reg != FMC_S_RESULT) begin
			o_res_valid <= 1'b0;
			res_idx_reg <= 4'd0;
		end else if (take_res) begin
			o_res_valid <= 1'b0;
			res_idx_reg <= res_idx_reg + 4'd1;
		end else if (!o_res_valid) begin
			o_res_valid <= 1'b1;
			o_res_data  <= res_mem[res_idx_reg];
		end
	end

	AST_SEEK_ENTERS_PARAM: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		(state_reg == FMC_S_IDLE && take_cmd
			&& (i_cmd_data & MSK_REL_SEEK) == OP_REL_SEEK)
		|=> state_reg == FMC_S_PARAM && npar_reg == 2'd2)
		else $error("relative seek did not wait for two bytes");
	AST_DUMP_NO_STEP: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		kind_reg == FMC_K_DUMP && state_reg == FMC_S_EXEC
		|=> !o_step && !o_rdid_req && state_reg == FMC_S_RESULT)
		else $error("register dump caused drive activity");
	AST_RDID_CRC_SKIP: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		o_rdid_req && i_id_valid && i_id_crc_err && !i_id_abort
		|=> o_rdid_req)
		else $error("read id accepted a field with an error");
	AST_PERP_BIT6: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		!o_perp_mode[PERP_ZERO_BIT])
		else $error("perpendicular bit 6 not zero");
	AST_INVALID_RES: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		o_res_valid && kind_reg == FMC_K_INVAL
		|-> o_res_data == ST0_INVALID && o_standby)
		else $error("invalid opcode result not 80h");
	AST_LOCK_RES: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		o_res_valid && kind_reg == FMC_K_LOCK
		|-> o_res_data == {3'b000, o_lock, 4'h0})
		else $error("lock result wrong");
	AST_DUMP_LEN: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		take_res && kind_reg == FMC_K_DUMP && res_idx_reg == 4'd9
		|=> state_reg == FMC_S_IDLE)
		else $error("dump result length not ten");
	AST_SHARED_BYTE: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		state_reg == FMC_S_EXEC && kind_reg == FMC_K_DUMP
		|=> res_mem[6] == ($past(i_last_was_format)
			? $past(i_sectors_per_cylinder)
			: $past(i_end_of_track_sector)))
		else $error("shared dump byte wrong");
	AST_SEEK_PCN: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		seek_done |=> pcn_reg[sel_drv] == ($past(dir_reg)
			? $past(pcn_reg[sel_drv]) + $past(par_reg[1])
			: $past(pcn_reg[sel_drv]) - $past(par_reg[1])))
		else $error("present cylinder not updated by seek");
	AST_STEP_ONLY_SEEK: assert property (@(posedge i_sys_clk)
		disable iff (!i_rst_n)
		o_step |-> state_reg == FMC_S_EXEC && kind_reg == FMC_K_SEEK)
		else $error("head step outside a relative seek");

	COV_SEEK: cover property (@(posedge i_sys_clk) seek_done);
	COV_DUMP: cover property (@(posedge i_sys_clk)
		take_res && kind_reg == FMC_K_DUMP && res_idx_reg == 4'd9);
	COV_RDID: cover property (@(posedge i_sys_clk)
		o_rdid_req && i_id_valid && !i_id_crc_err);
	COV_INVAL: cover property (@(posedge i_sys_clk)
		o_res_valid && kind_reg == FMC_K_INVAL);
endmodule : fmc_cmd_decoder

// ### design/fmc_pkg.sv
package fmc_pkg;
	// Opcode patterns; masks strip the option bits carried in the opcode
	localparam logic [7:0] OP_REL_SEEK   = 8'h8f; // Bit 6 is direction
	localparam logic [7:0] MSK_REL_SEEK  = 8'hbf;
	localparam logic [7:0] OP_REG_DUMP   = 8'h0e;
	localparam logic [7:0] OP_READ_ID    = 8'h0a; // Bit 6 is density
	localparam logic [7:0] MSK_READ_ID   = 8'hbf;
	localparam logic [7:0] OP_PERP_MODE  = 8'h12;
	localparam logic [7:0] OP_LOCK       = 8'h14; // Bit 7 is lock value
	localparam logic [7:0] MSK_LOCK      = 8'h7f;
	// Opcode option, lock result and perpendicular setting bit positions
	localparam int         DIR_BIT       = 6;
	localparam int         LOCK_BIT      = 7;
	localparam int         LOCK_RES_BIT  = 4;
	localparam int         PERP_ZERO_BIT = 6;
	// Fixed result and reset values
	localparam logic [7:0] ST0_INVALID   = 8'h80;
	localparam logic [7:0] PERP_RST      = 8'h00;
	localparam logic [7:0] PCN_RST       = 8'h00;
	// Parameter byte counts and result lengths
	localparam logic [1:0] NPAR_REL_SEEK = 2'd2;
	localparam logic [1:0] NPAR_ONE      = 2'd1;
	localparam logic [3:0] NRES_DUMP     = 4'd10;
	localparam logic [3:0] NRES_READ_ID  = 4'd7;
	localparam logic [3:0] NRES_ONE      = 4'd1;
	// Spacing between head steps
	localparam int         CLK_NS        = 25;
	localparam int         STEP_GAP_NS   = 3000;
	localparam int         STEP_GAP_CYC  = (STEP_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] STEP_GAP_CNT  = 8'(STEP_GAP_CYC);

	// Command kinds
	typedef enum logic [2:0] {
		FMC_K_NONE  = 3'd0,
		FMC_K_SEEK  = 3'd1,
		FMC_K_DUMP  = 3'd2,
		FMC_K_RDID  = 3'd3,
		FMC_K_PERP  = 3'd4,
		FMC_K_LOCK  = 3'd5,
		FMC_K_INVAL = 3'd6
	} fmc_kind_e;

	// Phases, Gray along idle-param-exec-result
	typedef enum logic [1:0] {
		FMC_S_IDLE   = 2'b00,
		FMC_S_PARAM  = 2'b01,
		FMC_S_EXEC   = 2'b11,
		FMC_S_RESULT = 2'b10
	} fmc_state_e;
endpackage : fmc_pkg

// ### design/fmc_stepper.sv
`timescale 1ns/10ps
module fmc_stepper
	import fmc_pkg::*;
(
	input  wire logic       i_sys_clk, // System clock
	input  wire logic       i_rst_n,   // Sync reset, active low
	input  wire logic       i_start,   // Start a step burst
	input  wire logic [7:0] i_count,   // Steps to issue
	output logic            o_step,    // One-cycle step pulse
	output logic            o_done     // One-cycle burst end
);
	logic [7:0] left_reg;
	logic [7:0] gap_reg;
	logic       busy_reg;

	// Burst sequencer; a zero count ends at once
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			left_reg <= 8'h00;
			gap_reg  <= 8'h00;
			busy_reg <= 1'b0;
			o_step   <= 1'b0;
			o_done   <= 1'b0;
		end else begin
			o_step <= 1'b0;
			o_done <= 1'b0;
			if (i_start && !busy_reg) begin
				left_reg <= i_count;
				gap_reg  <= 8'h00;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (gap_reg != 8'h00) begin
					gap_reg <= gap_reg - 8'h01;
				end else if (left_reg == 8'h00) begin
					busy_reg <= 1'b0;
					o_done   <= 1'b1;
				end else begin
					// Spacing keeps the drive within its step rate
					o_step   <= 1'b1;
					left_reg <= left_reg - 8'h01;
					gap_reg  <= STEP_GAP_CNT;
				end
			end
		end
	end
endmodule : fmc_stepper

// ### tb/fmc_host_model.sv
`timescale 1ns/10ps
// Host side: offers command bytes and takes result bytes, sometimes slowly
module fmc_host_model (
	input  wire logic       i_sys_clk,   // System clock
	input  wire logic       i_cmd_ready, // Decoder can take a byte
	output logic            o_cmd_valid, // Command byte offered
	output logic [7:0]      o_cmd_data,  // Command byte
	output logic            o_res_ready  // Host takes result byte
);
	int seed = 32'h0cb4;

	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_data  = 8'h00;
		o_res_ready = 1'b0;
	end

	function automatic logic [31:0] rnd();
		return $random(seed);
	endfunction : rnd

	// Random read stalls, a real host is not always prompt
	always @(negedge i_sys_clk) begin
		o_res_ready <= (2'($random(seed)) != 2'd0);
	end

	// Drive bits are passed as given: caller keeps them matching
	task automatic send(input logic [7:0] b);
		@(negedge i_sys_clk);
		o_cmd_valid = 1'b1;
		o_cmd_data  = b;
		while (i_cmd_ready !== 1'b1) begin
			@(negedge i_sys_clk);
		end
		@(posedge i_sys_clk);
		@(negedge i_sys_clk);
		o_cmd_valid = 1'b0;
		o_cmd_data  = ~b; // Released bus shows no stale byte
	endtask : send
endmodule : fmc_host_model

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	import fmc_pkg::*;
	logic        i_sys_clk, i_rst_n, i_cmd_valid, i_ext_claim, i_res_ready;
	logic [7:0]  i_cmd_data, i_sectors_per_cylinder, i_end_of_track_sector;
	logic [3:0]  i_step_rate_time, i_head_unload_time, i_fifo_threshold;
	logic [6:0]  i_head_load_time;
	logic        i_non_dma_select, i_last_was_format, i_implied_seek_enable;
	logic        i_fifo_disable_bit, i_poll_disable, i_pcn_load, i_id_valid;
	logic        i_id_crc_err, i_id_abort;
	logic [7:0]  i_precomp_start_track, i_pcn_value, i_id_st0, i_id_st1;
	logic [7:0]  i_id_st2, o_res_data, o_perp_mode;
	logic [1:0]  i_pcn_drive;
	logic [31:0] i_id_chrn;
	logic        o_cmd_ready, o_res_valid, o_step, o_step_dir, o_seek_done;
	logic        o_rdid_req, o_rdid_head, o_rdid_dens, o_standby, o_lock;
	logic [7:0]  exp_q[$];
	logic [7:0]  pcn_exp[4];
	logic        lock_exp, last_dir;
	logic [7:0]  perp_exp;
	int          failures, n_checks, steps, cyc;

	fmc_host_model i_host (.i_sys_clk(i_sys_clk), .i_cmd_ready(o_cmd_ready),
		.o_cmd_valid(i_cmd_valid), .o_cmd_data(i_cmd_data),
		.o_res_ready(i_res_ready));

	fmc_cmd_decoder i_fmc_cmd_decoder (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
		.i_cmd_data(i_cmd_data), .o_cmd_ready(o_cmd_ready),
		.i_ext_claim(i_ext_claim), .o_res_valid(o_res_valid),
		.o_res_data(o_res_data), .i_res_ready(i_res_ready),
		.i_step_rate_time(i_step_rate_time),
		.i_head_unload_time(i_head_unload_time),
		.i_head_load_time(i_head_load_time),
		.i_non_dma_select(i_non_dma_select),
		.i_sectors_per_cylinder(i_sectors_per_cylinder),
		.i_end_of_track_sector(i_end_of_track_sector),
		.i_last_was_format(i_last_was_format),
		.i_implied_seek_enable(i_implied_seek_enable),
		.i_fifo_disable_bit(i_fifo_disable_bit),
		.i_poll_disable(i_poll_disable), .i_fifo_threshold(i_fifo_threshold),
		.i_precomp_start_track(i_precomp_start_track),
		.i_pcn_load(i_pcn_load), .i_pcn_drive(i_pcn_drive),
		.i_pcn_value(i_pcn_value), .o_step(o_step), .o_step_dir(o_step_dir),
		.o_seek_done(o_seek_done), .o_rdid_req(o_rdid_req),
		.o_rdid_head(o_rdid_head), .o_rdid_dens(o_rdid_dens),
		.i_id_valid(i_id_valid), .i_id_crc_err(i_id_crc_err),
		.i_id_abort(i_id_abort), .i_id_st0(i_id_st0), .i_id_st1(i_id_st1),
		.i_id_st2(i_id_st2), .i_id_chrn(i_id_chrn), .o_standby(o_standby),
		.o_lock(o_lock), .o_perp_mode(o_perp_mode));

	// Clock, 25 ns period
	initial begin
		i_sys_clk = 1'b0;
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
		input string msg);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp, input string msg);
		chk8({7'h00, got}, {7'h00, exp}, msg);
	endtask : chk1

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	// Scoreboard: every taken result byte against the oldest note
	always @(posedge i_sys_clk) begin
		if (i_rst_n === 1'b1 && o_res_valid === 1'b1
			&& i_res_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				failures++;
				$display("mismatch at %0t: unexpected result byte", $time);
			end else begin
				chk8(o_res_data, exp_q.pop_front(), "result");
			end
		end
	end

	// Step pulses counted, direction noted; hang guard
	always @(posedge i_sys_clk) begin
		cyc++;
		if (o_step === 1'b1) begin
			steps++;
			last_dir = o_step_dir;
		end
		if (cyc == 40000) begin
			failures++;
			stop_test();
		end
	end

	// Bounded wait for all noted results, then no stray byte
	task automatic drain;
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 3000) begin
			@(negedge i_sys_clk);
			n++;
		end
		// A stalled result phase must not pass as an empty queue
		chk8(8'(exp_q.size()), 8'h00, "results missing");
		exp_q.delete();
		repeat (3) @(negedge i_sys_clk);
		chk1(o_res_valid, 1'b0, "result left");
	endtask : drain

	task automatic lock_cmd(input logic l);
		exp_q.push_back({3'b000, l, 4'h0});
		i_host.send({l, 7'h14});
		lock_exp = l;
		drain();
		chk1(o_lock, l, "lock");
	endtask : lock_cmd

	task automatic rseek(input logic dir, input logic [1:0] drv,
		input logic [7:0] cnt);
		int s, n;
		s = steps;
		n = 0;
		i_host.send({1'b1, dir, 6'b001111});
		i_host.send({6'h00, drv});
		i_host.send(cnt);
		while (o_seek_done !== 1'b1 && n < 2000) begin
			@(negedge i_sys_clk);
			n++;
		end
		chk1(o_seek_done, 1'b1, "seek done");
		chk8(8'(steps - s), cnt, "step count");
		if (cnt != 8'h00)
			chk1(last_dir, dir, "step dir");
		pcn_exp[drv] = dir ? pcn_exp[drv] + cnt : pcn_exp[drv] - cnt;
	endtask : rseek

	// Fresh settings each dump, shared byte follows last command kind
	task automatic dump(input logic fmt);
		int s;
		@(negedge i_sys_clk);
		{i_step_rate_time, i_head_unload_time, i_head_load_time,
			i_non_dma_select} = 16'(i_host.rnd());
		{i_sectors_per_cylinder, i_end_of_track_sector,
			i_precomp_start_track} = 24'(i_host.rnd());
		{i_implied_seek_enable, i_fifo_disable_bit, i_poll_disable,
			i_fifo_threshold} = 7'(i_host.rnd());
		i_last_was_format = fmt;
		for (int d = 0; d < 4; d++)
			exp_q.push_back(pcn_exp[d]);
		exp_q.push_back({i_step_rate_time, i_head_unload_time});
		exp_q.push_back({i_head_load_time, i_non_dma_select});
		exp_q.push_back(fmt ? i_sectors_per_cylinder : i_end_of_track_sector);
		exp_q.push_back({lock_exp, 1'b0, perp_exp[5:0]});
		exp_q.push_back({1'b0, i_implied_seek_enable, i_fifo_disable_bit,
			i_poll_disable, i_fifo_threshold});
		exp_q.push_back(i_precomp_start_track);
		s = steps;
		i_host.send(OP_REG_DUMP);
		drain();
		chk8(8'(steps - s), 8'h00, "dump stepped");
		$display("test dump %0d done", fmt);
	endtask : dump

	// A damaged field first, then a good one or a given-up search
	task automatic read_id(input logic m);
		@(negedge i_sys_clk);
		i_id_crc_err = 1'b1;
		i_id_chrn    = i_host.rnd();
		i_host.send({1'b0, m, 6'h0a});
		i_host.send({5'h00, m, 2'b00});
		repeat (2) @(negedge i_sys_clk);
		chk1(o_rdid_req, 1'b1, "search");
		chk1(o_rdid_head, m, "head");
		chk1(o_rdid_dens, m, "density");
		i_id_valid = 1'b1;
		@(negedge i_sys_clk);
		i_id_valid   = 1'b0;
		i_id_crc_err = 1'b0;
		{i_id_st0, i_id_st1, i_id_st2} = 24'(i_host.rnd());
		i_id_chrn = i_host.rnd();
		@(negedge i_sys_clk);
		chk1(o_rdid_req, 1'b1, "bad field taken");
		exp_q.push_back(i_id_st0);
		exp_q.push_back(i_id_st1);
		exp_q.push_back(i_id_st2);
		for (int b = 3; b >= 0; b--)
			exp_q.push_back(i_id_chrn[b*8 +: 8]);
		if (m)
			i_id_valid = 1'b1;
		else
			i_id_abort = 1'b1;
		@(negedge i_sys_clk);
		{i_id_valid, i_id_abort} = 2'b00;
		drain();
		$display("test read id %0d done", m);
	endtask : read_id

	initial begin
		{i_rst_n, i_ext_claim, i_step_rate_time, i_head_unload_time} = '0;
		{i_head_load_time, i_non_dma_select, i_sectors_per_cylinder} = '0;
		{i_end_of_track_sector, i_last_was_format, i_implied_seek_enable} = '0;
		{i_fifo_disable_bit, i_poll_disable, i_fifo_threshold} = '0;
		{i_precomp_start_track, i_pcn_load, i_pcn_drive, i_pcn_value} = '0;
		{i_id_valid, i_id_crc_err, i_id_abort, i_id_st0, i_id_st1} = '0;
		{i_id_st2, i_id_chrn} = '0;
		pcn_exp  = '{default: PCN_RST};
		lock_exp = 1'b0;
		perp_exp = PERP_RST;
		repeat (5) @(negedge i_sys_clk);
		i_rst_n = 1'b1;
		chk1(o_cmd_ready, 1'b1, "reset ready");
		chk1(o_standby, 1'b0, "reset standby");
		chk8(o_perp_mode, PERP_RST, "reset perp");
		dump(1'b0);
		lock_cmd(1'b1);
		lock_cmd(1'b0);
		$display("test lock done");
		for (int k = 0; k < 2; k++) begin
			perp_exp = 8'(i_host.rnd()) | (k ? 8'h40 : 8'h00);
			i_host.send(OP_PERP_MODE);
			i_host.send(perp_exp);
			perp_exp[PERP_ZERO_BIT] = 1'b0;
			repeat (2) @(negedge i_sys_clk);
			chk8(o_perp_mode, perp_exp, "perp");
		end
		$display("test perp done");
		i_ext_claim = 1'b1;
		i_host.send(8'hff);
		i_ext_claim = 1'b0;
		drain();
		for (int k = 0; k < 2; k++) begin
			exp_q.push_back(ST0_INVALID);
			i_host.send(k ? 8'hff : 8'h00);
			chk1(o_standby, 1'b1, "standby");
			drain();
		end
		lock_cmd(1'b1);
		chk1(o_standby, 1'b0, "standby left");
		$display("test invalid done");
		rseek(1'b1, 2'd2, 8'd3);
		rseek(1'b0, 2'd2, 8'd5);
		rseek(1'b1, 2'd1, 8'd0);
		@(negedge i_sys_clk);
		{i_pcn_load, i_pcn_drive, i_pcn_value} = {3'b111, 8'(i_host.rnd())};
		pcn_exp[3] = i_pcn_value;
		@(negedge i_sys_clk);
		i_pcn_load = 1'b0;
		$display("test seek done");
		dump(1'b1);
		dump(1'b0);
		read_id(1'b1);
		read_id(1'b0);
		stop_test();
	end
endmodule : testbench
